// *** rtl/cvp_map.svh ***
// Purpose: Register map, field layout, reset values and timing constants
// Assumes: 200 MHz clock, 32-bit register port
// Notes:   Definitions only
`ifndef CVP_MAP_SVH
`define CVP_MAP_SVH

`define CVP_ADDR_W          8
`define CVP_CFG0_ADDR       8'h00
`define CVP_CFG1_ADDR       8'h04
`define CVP_STATUS_ADDR     8'h08
`define CVP_MASK_ADDR       8'h0C
`define CVP_STATE_ADDR      8'h10

// Config 0 fields
`define CVP_OV_THR_LSB      0
`define CVP_OV_DLY_LSB      8
`define CVP_OV_HYS_LSB      12
`define CVP_UV_THR_LSB      16
`define CVP_UV_DLY_LSB      20
`define CVP_UV_HYS_LSB      24
// Config 1 fields
`define CVP_REC_SEL_BIT     0
`define CVP_SD_EN_BIT       1
`define CVP_CELLS_LSB       4
`define CVP_BAL_LSB         8

`define CVP_CFG0_RST        32'h0000_0000
`define CVP_CFG1_RST        32'h0000_00A0
`define CVP_MASK_RST        5'h00

`define CVP_NUM_CELLS       10
`define CVP_MIN_CELLS       4'h4
`define CVP_MAX_CELLS       4'hA
`define CVP_NUM_EVT         5

// Timing: times in their own unit, cycles derived in code
`define CVP_CLK_PERIOD_NS   5
`define CVP_TICK_MS         1
`define CVP_OV_DLY_BASE_MS  16'h01F4
`define CVP_OV_DLY_STEP_MS  16'h00FA
`define CVP_UV_DLY_BASE_MS  16'h01F4
`define CVP_UV_DLY_MAX_CODE 3'h6
`define CVP_SD_DLY_MS       16'h1F40

`endif

// *** rtl/cvp_pkg.sv ***
// Purpose: Types shared by the protection logic
// Assumes: Constants live in cvp_map.svh
// Notes:   Threshold fields are codes sent to the analog comparators
package cvp_pkg;

	typedef enum logic [2:0] {
		ST_NORMAL   = 3'b001,
		ST_UV_PROT  = 3'b010,
		ST_SHUTDOWN = 3'b100
	} cvp_state_e;

	typedef enum logic [1:0] {
		BAL_OFF      = 2'h0,
		BAL_ALWAYS   = 2'h1,
		BAL_CHARGE_ONLY = 2'h2
	} cvp_bal_e;

	typedef struct packed {
		logic [1:0] uv_hyst;
		logic [2:0] uv_delay;
		logic [3:0] uv_thresh;
		logic [3:0] ov_hyst;
		logic [2:0] ov_delay;
		logic [5:0] ov_thresh;
	} cvp_thr_s;

	// Per-cell comparator results, bit n for cell n
	typedef struct packed {
		logic [9:0] above_ov;
		logic [9:0] below_ov_rec;
		logic [9:0] below_uv;
		logic [9:0] above_undervoltage_recovery_select;
	} cvp_cells_s;

	typedef struct packed {
		logic charge_fet_enable;
		logic discharge_fet_enable;
		logic regulator_enable;
		logic balance_enable;
	} cvp_drive_s;

endpackage

// *** rtl/cvp_delay_timer.sv ***
// Purpose: Fault delay counter in millisecond ticks
// Assumes: tick is a one-cycle pulse per millisecond
// Notes:   Restarts whenever the condition drops
module cvp_delay_timer (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        cond,
	input  wire logic [15:0] limit,
	output logic             expired
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic        exp_ff;
	logic        nxt_exp;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_exp = 1'b0;
		if (!cond) begin
			nxt_cnt = 16'h0000;
		end else begin
			if (tick && cnt_ff < limit)
				nxt_cnt = cnt_ff + 16'h0001;
			nxt_exp = (cnt_ff >= limit);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_ff <= 16'h0000;
			exp_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			exp_ff <= nxt_exp;
		end
	end

	assign expired = exp_ff;
endmodule

// *** rtl/cvp_core.sv ***
// Purpose: Cell over/undervoltage protection and FET control
// Assumes: Comparator inputs synchronous to clock
// Notes:   Delays counted in 1 ms ticks; TICK_CYCLES shortens them
`include "cvp_map.svh"

// Function
// - Charge FET off after any cell stays above OV threshold past delay.
// - Charge FET stays off until all cells below OV minus hysteresis.
// - OV threshold, delay, hysteresis taken from configuration fields.
// - Any cell under UV for delay enters UV state, discharge FET off.
// - UV threshold, delay and hysteresis configurable; delay binary spaced.
// - Recovery select clear: discharge FET back once cells above UV+hyst.
// - Recovery select set: also needs load removal before discharge FET.
// - Shutdown enable set: cell under UV+hyst over 8 s enters shutdown.
// - Shutdown enable clear: UV fault never causes shutdown.
// - Shutdown turns regulator off; only charger insertion leaves it.
// - Charger present when charger sense comparator reports above level.
// - Load removal flagged while discharge FET off and pack-negative low.
// - Balancing modes: always, only while charging, or disabled.
module cvp_core #(
	parameter int TICK_CYCLES =
		`CVP_TICK_MS * 1000000 / `CVP_CLK_PERIOD_NS
) (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [31:0]             reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic [31:0]                  reg_rdata,
	input  wire cvp_pkg::cvp_cells_s     cells,
	input  wire logic                    charger_sense_pin,
	input  wire logic                    pack_negative_sense_pin,
	output cvp_pkg::cvp_thr_s            thresholds,
	output cvp_pkg::cvp_drive_s          drive,
	output logic                         irq
);
	localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

	logic [31:0]         cfg0_ff;
	logic [31:0]         nxt_cfg0;
	logic [31:0]         cfg1_ff;
	logic [31:0]         nxt_cfg1;
	logic [4:0]          status_ff;
	logic [4:0]          nxt_status;
	logic [4:0]          mask_ff;
	logic [4:0]          nxt_mask;
	logic [31:0]         rdata_ff;
	logic [31:0]         nxt_rdata;
	logic                irq_ff;
	logic                nxt_irq;
	logic [17:0]         tick_cnt_ff;
	logic [17:0]         nxt_tick_cnt;
	logic                tick;
	cvp_pkg::cvp_state_e state_ff;
	cvp_pkg::cvp_state_e nxt_state;
	logic                ov_fault_ff;
	logic                nxt_ov_fault;
	logic                load_removed_ff;
	logic                nxt_load_removed;
	logic                charger_prev_ff;
	cvp_pkg::cvp_drive_s drive_ff;
	cvp_pkg::cvp_drive_s nxt_drive;
	cvp_pkg::cvp_thr_s   thr;
	logic [9:0]          mask;
	logic                any_ov;
	logic                all_ov_clear;
	logic                any_uv;
	logic                all_uv_clear;
	logic                charger_in;
	logic                ov_cond;
	logic                uv_cond;
	logic                sd_cond;
	logic                ov_exp;
	logic                uv_exp;
	logic                sd_exp;
	logic                rec_sel;
	logic                sd_en;
	logic [4:0]          events;

	// Cells above the configured count, clamped to 4..10, are ignored
	function automatic logic [9:0] cell_mask(input logic [3:0] n);
		logic [3:0] c;
		c = n;
		if (c < `CVP_MIN_CELLS)
			c = `CVP_MIN_CELLS;
		if (c > `CVP_MAX_CELLS)
			c = `CVP_MAX_CELLS;
		cell_mask = 10'((11'h001 << c) - 11'h001);
	endfunction

	function automatic logic [15:0] ov_delay_ms(input logic [2:0] code);
		ov_delay_ms = `CVP_OV_DLY_BASE_MS
			+ 16'(`CVP_OV_DLY_STEP_MS * {13'h0000, code});
	endfunction

	function automatic logic [15:0] uv_delay_ms(input logic [2:0] code);
		logic [2:0] c;
		c = (code > `CVP_UV_DLY_MAX_CODE) ? `CVP_UV_DLY_MAX_CODE : code;
		uv_delay_ms = `CVP_UV_DLY_BASE_MS << c;
	endfunction

	// Fields start on nibble boundaries, so the gaps between them are skipped
	assign thr = {
		cfg0_ff[`CVP_UV_HYS_LSB +: 2],
		cfg0_ff[`CVP_UV_DLY_LSB +: 3],
		cfg0_ff[`CVP_UV_THR_LSB +: 4],
		cfg0_ff[`CVP_OV_HYS_LSB +: 4],
		cfg0_ff[`CVP_OV_DLY_LSB +: 3],
		cfg0_ff[`CVP_OV_THR_LSB +: 6]
	};
	assign rec_sel = cfg1_ff[`CVP_REC_SEL_BIT];
	assign sd_en   = cfg1_ff[`CVP_SD_EN_BIT];

	// Comparator evaluation
	always_comb begin
		mask         = cell_mask(cfg1_ff[`CVP_CELLS_LSB +: 4]);
		any_ov       = |(cells.above_ov & mask);
		all_ov_clear = &(cells.below_ov_rec | ~mask);
		any_uv       = |(cells.below_uv & mask);
		all_uv_clear = &(cells.above_undervoltage_recovery_select | ~mask);
		charger_in   = charger_sense_pin && !charger_prev_ff;
		ov_cond      = any_ov && !ov_fault_ff;
		uv_cond      = any_uv && (state_ff == cvp_pkg::ST_NORMAL);
		sd_cond      = sd_en && !all_uv_clear
			&& (state_ff == cvp_pkg::ST_UV_PROT);
	end

	// Millisecond timebase
	always_comb begin
		tick         = (tick_cnt_ff == TICK_LAST);
		nxt_tick_cnt = tick ? 18'h0_0000 : tick_cnt_ff + 18'h0_0001;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			tick_cnt_ff <= 18'h0_0000;
		else
			tick_cnt_ff <= nxt_tick_cnt;
	end

	cvp_delay_timer u_ov_timer (
		.clock   (clock),
		.rst     (rst),
		.tick    (tick),
		.cond    (ov_cond),
		.limit   (ov_delay_ms(thr.ov_delay)),
		.expired (ov_exp)
	);

	cvp_delay_timer u_uv_timer (
		.clock   (clock),
		.rst     (rst),
		.tick    (tick),
		.cond    (uv_cond),
		.limit   (uv_delay_ms(thr.uv_delay)),
		.expired (uv_exp)
	);

	cvp_delay_timer u_sd_timer (
		.clock   (clock),
		.rst     (rst),
		.tick    (tick),
		.cond    (sd_cond),
		.limit   (`CVP_SD_DLY_MS),
		.expired (sd_exp)
	);

	// Protection state
	always_comb begin
		nxt_state    = state_ff;
		nxt_ov_fault = ov_fault_ff;
		if (ov_cond && ov_exp)
			nxt_ov_fault = 1'b1;
		else if (ov_fault_ff && all_ov_clear)
			nxt_ov_fault = 1'b0;
		unique case (state_ff)
			cvp_pkg::ST_NORMAL: begin
				if (uv_cond && uv_exp)
					nxt_state = cvp_pkg::ST_UV_PROT;
			end
			cvp_pkg::ST_UV_PROT: begin
				if (sd_cond && sd_exp)
					nxt_state = cvp_pkg::ST_SHUTDOWN;
				else if (all_uv_clear && !rec_sel)
					nxt_state = cvp_pkg::ST_NORMAL;
				else if (all_uv_clear && load_removed_ff)
					nxt_state = cvp_pkg::ST_NORMAL;
			end
			cvp_pkg::ST_SHUTDOWN: begin
				// Cells may still be low, so recovery rules apply again
				if (charger_in)
					nxt_state = cvp_pkg::ST_UV_PROT;
			end
			default: nxt_state = cvp_pkg::ST_UV_PROT;
		endcase
		// Only meaningful while the discharge FET is open
		nxt_load_removed = !drive_ff.discharge_fet_enable
			&& !pack_negative_sense_pin;
	end

	// FET, regulator and balancing drive
	always_comb begin
		nxt_drive.charge_fet_enable = !nxt_ov_fault
			&& (nxt_state != cvp_pkg::ST_SHUTDOWN);
		nxt_drive.discharge_fet_enable =
			(nxt_state == cvp_pkg::ST_NORMAL);
		nxt_drive.regulator_enable =
			(nxt_state != cvp_pkg::ST_SHUTDOWN);
		unique case (cvp_pkg::cvp_bal_e'(cfg1_ff[`CVP_BAL_LSB +: 2]))
			cvp_pkg::BAL_ALWAYS:   nxt_drive.balance_enable = 1'b1;
			cvp_pkg::BAL_CHARGE_ONLY: nxt_drive.balance_enable =
				charger_sense_pin;
			cvp_pkg::BAL_OFF:      nxt_drive.balance_enable = 1'b0;
			default:               nxt_drive.balance_enable = 1'b0;
		endcase
		if (nxt_state == cvp_pkg::ST_SHUTDOWN)
			nxt_drive.balance_enable = 1'b0;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff        <= cvp_pkg::ST_NORMAL;
			ov_fault_ff     <= 1'b0;
			load_removed_ff <= 1'b0;
			charger_prev_ff <= 1'b0;
			drive_ff        <= '0;
		end else begin
			state_ff        <= nxt_state;
			ov_fault_ff     <= nxt_ov_fault;
			load_removed_ff <= nxt_load_removed;
			charger_prev_ff <= charger_sense_pin;
			drive_ff        <= nxt_drive;
		end
	end

	// Register port and interrupt
	always_comb begin
		events = {charger_in,
			nxt_load_removed && !load_removed_ff,
			nxt_state == cvp_pkg::ST_SHUTDOWN
				&& state_ff != cvp_pkg::ST_SHUTDOWN,
			nxt_state == cvp_pkg::ST_UV_PROT
				&& state_ff == cvp_pkg::ST_NORMAL,
			nxt_ov_fault && !ov_fault_ff};
		nxt_cfg0   = cfg0_ff;
		nxt_cfg1   = cfg1_ff;
		nxt_mask   = mask_ff;
		nxt_status = status_ff;
		nxt_rdata  = 32'h0000_0000;
		if (reg_write) begin
			unique case (reg_addr)
				`CVP_CFG0_ADDR: nxt_cfg0 = {6'h00, reg_wdata[25:0]};
				`CVP_CFG1_ADDR: nxt_cfg1 = {22'h00_0000, reg_wdata[9:0]};
				`CVP_MASK_ADDR: nxt_mask = reg_wdata[4:0];
				default: ;
			endcase
		end
		if (reg_read) begin
			unique case (reg_addr)
				`CVP_CFG0_ADDR:   nxt_rdata = cfg0_ff;
				`CVP_CFG1_ADDR:   nxt_rdata = cfg1_ff;
				`CVP_STATUS_ADDR: begin
					nxt_rdata  = {27'h000_0000, status_ff};
					nxt_status = 5'h00;
				end
				`CVP_MASK_ADDR:   nxt_rdata = {27'h000_0000, mask_ff};
				`CVP_STATE_ADDR:  nxt_rdata = {23'h00_0000,
					load_removed_ff, ov_fault_ff, state_ff,
					drive_ff};
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
		// A new event wins over the read-clear
		nxt_status = nxt_status | events;
		nxt_irq    = |(nxt_status & mask_ff);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg0_ff   <= `CVP_CFG0_RST;
			cfg1_ff   <= `CVP_CFG1_RST;
			mask_ff   <= `CVP_MASK_RST;
			status_ff <= 5'h00;
			rdata_ff  <= 32'h0000_0000;
			irq_ff    <= 1'b0;
		end else begin
			cfg0_ff   <= nxt_cfg0;
			cfg1_ff   <= nxt_cfg1;
			mask_ff   <= nxt_mask;
			status_ff <= nxt_status;
			rdata_ff  <= nxt_rdata;
			irq_ff    <= nxt_irq;
		end
	end

	assign reg_rdata  = rdata_ff;
	assign irq        = irq_ff;
	assign drive      = drive_ff;
	assign thresholds = thr;
endmodule

// *** tb/cvp_pack_model.sv ***
// Purpose: Cells, charger and load around the protector
// Assumes: Cell voltages in mV are driven by the bench
// Notes:   Ideal comparators; hysteresis steps 25 mV and 400 mV
module cvp_pack_model (
	input  wire logic [15:0]         cell_mv [10],
	input  wire logic                load_present,
	input  wire logic                charger_present,
	input  wire cvp_pkg::cvp_thr_s   thresholds,
	input  wire cvp_pkg::cvp_drive_s drive,
	output cvp_pkg::cvp_cells_s      cells,
	output logic                     charger_sense_pin,
	output logic                     pack_negative_sense_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] ov, ov_rec, uv, undervoltage_recovery_select;
	always_comb begin
		ov = 16'h0AF0 + 16'h0019 * thresholds.ov_thresh;
		ov_rec = ov - 16'h0019 * thresholds.ov_hyst;
		uv = 16'h0578 + 16'h0064 * thresholds.uv_thresh;
		undervoltage_recovery_select = uv + 16'h0190 * (thresholds.uv_hyst + 16'h0001);
		for (int i = 0; i < 10; i++) begin
			cells.above_ov[i] = cell_mv[i] > ov;
			cells.below_ov_rec[i] = cell_mv[i] < ov_rec;
			cells.below_uv[i] = cell_mv[i] < uv;
			cells.above_undervoltage_recovery_select[i] = cell_mv[i] > undervoltage_recovery_select;
		end
	end
	assign charger_sense_pin = charger_present;
	// A load holds the line up only while the FET is open
	assign pack_negative_sense_pin =
		load_present & ~drive.discharge_fet_enable;
endmodule

// *** tb/cvp_core_properties.sv ***
// Purpose: Port properties of the protection core
// Assumes: One clock, async active-high reset
// Notes:   Trip causes looked up 8 cycles back, clear of timer lag
module cvp_core_properties #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic                clock,
	input wire logic                rst,
	input wire logic [7:0]          reg_addr,
	input wire logic [31:0]         reg_wdata,
	input wire logic                reg_write,
	input wire logic                reg_read,
	input wire logic [31:0]         reg_rdata,
	input wire cvp_pkg::cvp_cells_s cells,
	input wire logic                charger_sense_pin,
	input wire logic                pack_negative_sense_pin,
	input wire cvp_pkg::cvp_thr_s   thresholds,
	input wire cvp_pkg::cvp_drive_s drive,
	input wire logic                irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read slot");
	a_thr_load: assert property (
		reg_write && reg_addr == 8'h00 |=>
		thresholds.ov_thresh == $past(reg_wdata[5:0]) &&
		thresholds.uv_thresh == $past(reg_wdata[19:16]))
		else $error("thresholds not loaded");
	a_thr_hold: assert property (
		!(reg_write && reg_addr == 8'h00) |=> $stable(thresholds))
		else $error("thresholds moved");
	a_ov_cause: assert property (
		$fell(drive.charge_fet_enable) && drive.regulator_enable
		|-> $past(|cells.above_ov, 8))
		else $error("charge off without overvoltage");
	a_ov_release: assert property (
		$rose(drive.charge_fet_enable) && $past(drive.regulator_enable)
		|-> $past(&cells.below_ov_rec[3:0]))
		else $error("charge on above recovery level");
	a_uv_cause: assert property (
		$fell(drive.discharge_fet_enable) && drive.regulator_enable
		|-> $past(|cells.below_uv, 8))
		else $error("discharge off without undervoltage");
	a_sd_all_off: assert property (
		!drive.regulator_enable |-> drive == 4'h0)
		else $error("output on in shutdown");
	a_sd_exit: assert property (
		!drive.regulator_enable && !charger_sense_pin && !$past(rst)
		|=> !drive.regulator_enable)
		else $error("shutdown left without charger");
	cover property ($fell(drive.charge_fet_enable));
	cover property ($fell(drive.regulator_enable));
	cover property ($rose(irq));
endmodule

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the protection core
// Assumes: One ms is TICK clock cycles
// Notes:   Short tick keeps the eight second shutdown affordable
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 2;
	logic                clock, rst, reg_write, reg_read, irq;
	logic                load_present, charger_present;
	logic                charger_sense_pin, pack_negative_sense_pin;
	logic [7:0]          reg_addr;
	logic [31:0]         reg_wdata, reg_rdata, rd_val;
	logic [15:0]         cell_mv [10];
	cvp_pkg::cvp_cells_s cells;
	cvp_pkg::cvp_thr_s   thresholds;
	cvp_pkg::cvp_drive_s drive;
	int                  err_count, samples_checked;

	cvp_core #(.TICK_CYCLES(TICK)) cvp_core_inst (.clock(clock), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .cells(cells),
		.charger_sense_pin(charger_sense_pin),
		.pack_negative_sense_pin(pack_negative_sense_pin),
		.thresholds(thresholds), .drive(drive), .irq(irq));
	cvp_pack_model cvp_pack_model_inst (.cell_mv(cell_mv),
		.load_present(load_present), .charger_present(charger_present),
		.thresholds(thresholds), .drive(drive), .cells(cells),
		.charger_sense_pin(charger_sense_pin),
		.pack_negative_sense_pin(pack_negative_sense_pin));

	always #2.5 clock = ~clock;

	task automatic end_sim;
		if (err_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		rd_val = reg_rdata;
	endtask
	task automatic setc(input int i, input logic [15:0] mv);
		@(posedge clock);
		cell_mv[i] <= mv;
	endtask
	// Bounded wait; lo catches a trip that comes early
	task automatic expect_at(input string w, input int b, input logic v,
		input int lo, input int hi);
		int n;
		n = 0;
		while (drive[b] !== v && n < hi) begin
			@(negedge clock);
			n++;
		end
		if (drive[b] !== v) begin
			chk(w, 32'(v), 32'(drive[b]));
			end_sim();
		end else begin
			chk(w, 32'h0000_0001, 32'(n >= lo));
		end
	endtask
	task automatic hold(input string w, input int b, input logic v,
		input int n);
		int bad;
		bad = 0;
		repeat (n) begin
			@(negedge clock);
			if (drive[b] !== v) bad++;
		end
		chk(w, 32'h0000_0000, 32'(bad));
	endtask
	task automatic t_reset;
		rd(8'h04);
		chk("cfg1", 32'h0000_00A0, rd_val);
		chk("drive", 32'h0000_000E, {28'h000_0000, drive});
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h00);
		chk("cfg0", 32'h0000_0000, rd_val);
		rd(8'h20);
		chk("unmapped", 32'h0000_0000, rd_val);
		rd(8'h08);
		chk("status rst", 32'h0000_0000, rd_val);
		rd(8'h10);
		chk("state rst", 32'h0000_001E, rd_val);
	endtask
	task automatic t_ov;
		wr(8'h00, 32'h0016_4128);
		@(negedge clock);
		chk("thr", {10'h000, 2'h0, 3'h1, 4'h6, 4'h4, 3'h1, 6'h28},
			{10'h000, thresholds});
		setc(3, 16'h0F3C);
		hold("ov short", 3, 1'b1, 1400);
		setc(3, 16'h0CE4);
		setc(3, 16'h0F3C);
		expect_at("ov trip", 3, 1'b0, 1490, 1520);
		chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
		setc(3, 16'h0EA6);
		hold("ov hyst", 3, 1'b0, 40);
		setc(3, 16'h0E42);
		expect_at("ov rec", 3, 1'b1, 0, 10);
		wr(8'h0C, 32'h0000_0001);
		repeat (2) @(negedge clock);
		chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
		rd(8'h08);
		chk("status", 32'h0000_0001, rd_val);
		repeat (2) @(negedge clock);
		chk("irq clr", 32'h0000_0000, {31'h0000_0000, irq});
	endtask
	task automatic t_uv;
		setc(5, 16'h076C);
		expect_at("uv trip", 2, 1'b0, 1990, 2020);
		setc(5, 16'h08FC);
		hold("no sd", 1, 1'b1, 16100);
		chk("uv hyst", 32'h0000_0000, {31'h0000_0000, drive[2]});
		setc(5, 16'h09C4);
		expect_at("undervoltage_recovery_select", 2, 1'b1, 0, 10);
	endtask
	task automatic t_uv_load;
		wr(8'h04, 32'h0000_00A1);
		setc(5, 16'h076C);
		expect_at("uv trip", 2, 1'b0, 1990, 2020);
		setc(5, 16'h09C4);
		hold("load on", 2, 1'b0, 40);
		@(posedge clock);
		load_present <= 1'b0;
		expect_at("load off", 2, 1'b1, 0, 10);
		@(posedge clock);
		load_present <= 1'b1;
	endtask
	task automatic t_sd;
		wr(8'h04, 32'h0000_00A2);
		setc(5, 16'h076C);
		expect_at("uv trip", 2, 1'b0, 1990, 2020);
		setc(5, 16'h08FC);
		expect_at("sd", 1, 1'b0, 15900, 16100);
		setc(5, 16'h0CE4);
		hold("sd stay", 1, 1'b0, 40);
		@(posedge clock);
		charger_present <= 1'b1;
		expect_at("wake", 1, 1'b1, 0, 10);
	endtask
	task automatic t_cells;
		wr(8'h04, 32'h0000_0040);
		setc(9, 16'h0F3C);
		hold("unused", 3, 1'b1, 1600);
		setc(9, 16'h0CE4);
	endtask
	task automatic bal(input logic [31:0] cfg, input logic c, input logic e);
		@(posedge clock);
		charger_present <= c;
		wr(8'h04, cfg);
		repeat (3) @(negedge clock);
		chk("balance", {31'h0000_0000, e}, {31'h0000_0000, drive[0]});
	endtask

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		load_present = 1'b1;
		charger_present = 1'b0;
		err_count = 0;
		samples_checked = 0;
		for (int i = 0; i < 10; i++) cell_mv[i] = 16'h0CE4;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_ov();
		t_uv();
		t_uv_load();
		t_sd();
		t_cells();
		bal(32'h0000_00A0, 1'b1, 1'b0);
		bal(32'h0000_01A0, 1'b0, 1'b1);
		bal(32'h0000_02A0, 1'b0, 1'b0);
		bal(32'h0000_02A0, 1'b1, 1'b1);
		bal(32'h0000_03A0, 1'b1, 1'b0);
		end_sim();
	end
endmodule

bind cvp_core cvp_core_properties #(.TICK_CYCLES(TICK_CYCLES))
	cvp_core_properties_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .cells(cells), .irq(irq),
	.charger_sense_pin(charger_sense_pin),
	.pack_negative_sense_pin(pack_negative_sense_pin),
	.thresholds(thresholds), .drive(drive));
